// File: src/outside_threshold_event_detect.sv
/*
 * outside-of-thresholds event detector with a classic wishbone slave.
 * assumes one i_odr_tick pulse per output-data-rate period from logic on
 * i_clk_sys, carrying the sample triplet of that period.
 */
// Notes on behaviour
// RQ1 - event flag bit 7 sets after OR of axis flags holds debounce periods
// RQ2 - event flag reads 0 at reset and when all enabled axes inside; latched mode holds it until a status read
// RQ3 - absolute mode compares samples, relative mode compares sample deltas
// RQ4 - only enabled axes count; no enables means no event ever
// RQ5 - wake setting restarts wake/sleep timer each period flag is set
// RQ6 - sleep is blocked while the event flag stays set
// RQ7 - x flag bit 5 set at or beyond a threshold, clear inside; latched mode holds it until a status read
// RQ8 - x polarity bit 4: 0 at or below lower, 1 at or above upper
// RQ9 - y flag bit 3 set at or beyond a threshold, clear inside; latched mode holds it until a status read
// RQ10 - y polarity bit 2: 0 at or below lower, 1 at or above upper
// RQ11 - z flag set at or beyond a threshold, meaningful when enabled
// RQ12 - z polarity bit 0: 0 at or below lower, 1 at or above upper
// RQ13 - polarity latched when axis flag sets; unlatched flags update at count
// RQ14 - event flag can be routed to either interrupt pin
// RQ15 - debounce counter clears in any period with no axis outside
`timescale 1ns/1ns

module outside_threshold_event_detect #(
	parameter int DBCNT_W = 8
) (
	input  wire logic                              i_clk_sys,
	input  wire logic                              i_rstn,
	input  wire logic                              i_wb_cyc,
	input  wire logic                              i_wb_stb,
	input  wire logic                              i_wb_we,
	input  wire logic [outside_detect_pkg::WB_AW-1:0] i_wb_adr,
	input  wire logic [3:0]                        i_wb_sel,
	input  wire logic [31:0]                       i_wb_dat,
	output logic [31:0]                            o_wb_dat,
	output logic                                   o_wb_ack,
	input  wire logic                              i_odr_tick,
	input  wire outside_detect_pkg::axis_sample_s  i_sample,
	output logic                                   o_wake_timer_restart,
	output logic                                   o_sleep_blocked,
	output logic                                   o_interrupt_pin_one,
	output logic                                   o_interrupt_pin_two,
	output logic                                   o_irq
);

	localparam int DW = outside_detect_pkg::DATA_W;
	localparam int NA = outside_detect_pkg::AXES;
	localparam int IW = outside_detect_pkg::IRQ_W;

	// ------------------------------------------------------------
	// parameter check
	// ------------------------------------------------------------
	generate
		if (DBCNT_W < 1 || DBCNT_W > 8)
		begin : g_bad_dbcnt_w
			$error("DBCNT_W must lie between 1 and 8");
		end
	endgenerate

	// ------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------

	// register select, shared by read and write paths
	typedef enum {
		SEL_STATUS,
		SEL_UPPER,
		SEL_LOWER,
		SEL_DEBOUNCE,
		SEL_CONFIG,
		SEL_IRQ_STAT,
		SEL_IRQ_MASK,
		SEL_NONE
	} reg_sel_e;

	function automatic reg_sel_e decode_reg(
		input logic [outside_detect_pkg::WB_AW-1:0] adr
	);
		reg_sel_e sel;
		sel = SEL_NONE;
		unique case (adr)
			outside_detect_pkg::OFS_STATUS:   sel = SEL_STATUS;
			outside_detect_pkg::OFS_UPPER:    sel = SEL_UPPER;
			outside_detect_pkg::OFS_LOWER:    sel = SEL_LOWER;
			outside_detect_pkg::OFS_DEBOUNCE: sel = SEL_DEBOUNCE;
			outside_detect_pkg::OFS_CONFIG:   sel = SEL_CONFIG;
			outside_detect_pkg::OFS_IRQ_STAT: sel = SEL_IRQ_STAT;
			outside_detect_pkg::OFS_IRQ_MASK: sel = SEL_IRQ_MASK;
			default:                          sel = SEL_NONE;
		endcase
		return sel;
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic signed [DW-1:0]     upper_threshold;
	logic signed [DW-1:0]     lower_threshold;
	logic [DBCNT_W-1:0]       outside_debounce_count;
	outside_detect_pkg::cfg_s cfg;
	logic [IW-1:0]            irq_status;
	logic [IW-1:0]            irq_mask;
	logic [DBCNT_W-1:0]       debounce_cnt;
	logic                     outside_event_active;
	logic [NA-1:0]            axis_flag;
	logic [NA-1:0]            axis_pol;
	logic signed [DW-1:0]     prev_sample [NA];

	logic                     bus_req;
	logic                     bus_commit;
	logic                     wr_commit;
	logic                     rd_commit;
	reg_sel_e                 cur_sel;
	logic [7:0]               status_word;

	assign bus_req    = i_wb_cyc & i_wb_stb;
	assign bus_commit = bus_req & o_wb_ack;
	assign wr_commit  = bus_commit & i_wb_we;
	assign rd_commit  = bus_commit & ~i_wb_we;
	assign cur_sel    = decode_reg(i_wb_adr);

	// ------------------------------------------------------------
	// per-axis comparison
	// ------------------------------------------------------------
	logic signed [DW-1:0] cur_sample [NA];
	logic [NA-1:0]        axis_out;
	logic [NA-1:0]        axis_high;
	logic [NA-1:0]        axis_en;
	logic signed [DW:0]   upper_ext;
	logic signed [DW:0]   lower_ext;

	assign cur_sample[0] = i_sample.x;
	assign cur_sample[1] = i_sample.y;
	assign cur_sample[2] = i_sample.z;
	assign axis_en       = {cfg.z_outside_enable,
		cfg.y_outside_enable,
		cfg.x_outside_enable};
	assign upper_ext     = {upper_threshold[DW-1], upper_threshold};
	assign lower_ext     = {lower_threshold[DW-1], lower_threshold};

	genvar ax;
	generate
		for (ax = 0; ax < NA; ax++)
		begin : g_axis
			logic signed [DW:0] value;

			// value under test: raw sample or delta, one bit wider
			always_comb
			begin
				if (cfg.relative_mode) // RQ3
					value = {cur_sample[ax][DW-1], cur_sample[ax]}
						- {prev_sample[ax][DW-1], prev_sample[ax]};
				else
					value = {cur_sample[ax][DW-1], cur_sample[ax]};
			end

			// inclusive on both thresholds, gated by the axis enable
			assign axis_out[ax]  = axis_en[ax] // RQ4
				& ((value >= upper_ext) | (value <= lower_ext)); // RQ7 RQ9 RQ11
			assign axis_high[ax] = value >= upper_ext;

			// previous sample for relative mode
			always_ff @(posedge i_clk_sys or negedge i_rstn)
			begin
				if (!i_rstn)
					prev_sample[ax] <= '0;
				else if (i_odr_tick)
					prev_sample[ax] <= cur_sample[ax];
			end
		end
	endgenerate

	logic any_out;
	logic count_reached;
	logic [DBCNT_W:0] cnt_plus;

	assign any_out       = |axis_out;
	assign cnt_plus      = {1'b0, debounce_cnt} + 1'b1;
	// periods including this one reach the debounce count
	assign count_reached = any_out
		& (cnt_plus >= {1'b0, outside_debounce_count}); // RQ1

	// ------------------------------------------------------------
	// debounce counter
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
			debounce_cnt <= '0;
		else if (i_odr_tick)
		begin
			if (!any_out)
				debounce_cnt <= '0; // RQ15
			else if (!(&debounce_cnt))
				debounce_cnt <= cnt_plus[DBCNT_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// event active flag
	// ------------------------------------------------------------
	// latched mode holds until a status read; a set beats the read clear
	// and the read clears only a flag it reported, so a set that lands
	// between data capture and ack is not lost
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
			outside_event_active <= 1'b0; // RQ2
		else if (i_odr_tick && count_reached)
			outside_event_active <= 1'b1; // RQ1
		else if (i_odr_tick && !any_out && !cfg.outside_event_latch_enable)
			outside_event_active <= 1'b0; // RQ2
		else if (rd_commit && cur_sel == SEL_STATUS
			&& cfg.outside_event_latch_enable
			&& o_wb_dat[outside_detect_pkg::ST_ACTIVE_BIT])
			outside_event_active <= 1'b0;
	end

	// ------------------------------------------------------------
	// axis flags and polarities
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			axis_flag <= '0;
			axis_pol  <= '0;
		end
		else if (i_odr_tick && count_reached)
		begin
			if (cfg.outside_event_latch_enable)
			begin
				axis_flag <= axis_flag | axis_out;
				// polarity caught only as an axis flag newly sets
				for (int i = 0; i < NA; i++)
					if (axis_out[i] && !axis_flag[i])
						axis_pol[i] <= axis_high[i]; // RQ13 RQ8 RQ10 RQ12
			end
			else
			begin
				axis_flag <= axis_out; // RQ13
				for (int i = 0; i < NA; i++)
					if (axis_out[i])
						axis_pol[i] <= axis_high[i]; // RQ8 RQ10 RQ12
			end
		end
		else if (i_odr_tick && !any_out && !cfg.outside_event_latch_enable)
			axis_flag <= '0; // RQ7 RQ9 RQ11
		else if (rd_commit && cur_sel == SEL_STATUS
			&& cfg.outside_event_latch_enable)
		begin
			// only flags the read reported; a later set survives
			for (int i = 0; i < NA; i++)
				if (o_wb_dat[outside_detect_pkg::ST_X_FLAG_BIT
					- outside_detect_pkg::ST_AXIS_STEP * i])
					axis_flag[i] <= 1'b0;
		end
	end

	// status word as software sees it
	always_comb
	begin
		status_word = outside_detect_pkg::STATUS_RESET;
		status_word[outside_detect_pkg::ST_ACTIVE_BIT] = outside_event_active;
		for (int i = 0; i < NA; i++)
		begin
			status_word[outside_detect_pkg::ST_X_FLAG_BIT
				- outside_detect_pkg::ST_AXIS_STEP * i] = axis_flag[i];
			status_word[outside_detect_pkg::ST_X_FLAG_BIT - 1
				- outside_detect_pkg::ST_AXIS_STEP * i] = axis_pol[i];
		end
	end

	// ------------------------------------------------------------
	// wake/sleep interaction and pins
	// ------------------------------------------------------------
	// restart pulse on every period the flag stands with wake enabled
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
			o_wake_timer_restart <= 1'b0;
		else
			o_wake_timer_restart <= i_odr_tick & outside_event_active
				& cfg.wake_on_outside_event; // RQ5
	end

	// sleep held off while the flag stands
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
			o_sleep_blocked <= 1'b0;
		else
			o_sleep_blocked <= outside_event_active; // RQ6
	end

	// routing of the event flag to the interrupt pins
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_interrupt_pin_one <= 1'b0;
			o_interrupt_pin_two <= 1'b0;
		end
		else
		begin
			o_interrupt_pin_one <= outside_event_active & cfg.route_pin_one; // RQ14
			o_interrupt_pin_two <= outside_event_active & cfg.route_pin_two; // RQ14
		end
	end

	// ------------------------------------------------------------
	// interrupt status and mask
	// ------------------------------------------------------------
	logic event_d;

	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
			event_d <= 1'b0;
		else
			event_d <= outside_event_active;
	end

	// sticky edges of the event flag; a read clears the bits it returned,
	// a new edge wins
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
			irq_status <= '0;
		else
		begin
			if (rd_commit && cur_sel == SEL_IRQ_STAT)
				irq_status <= irq_status & ~o_wb_dat[IW-1:0];
			if (outside_event_active && !event_d)
				irq_status[outside_detect_pkg::IRQ_RISE_BIT] <= 1'b1;
			if (!outside_event_active && event_d)
				irq_status[outside_detect_pkg::IRQ_FALL_BIT] <= 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
			o_irq <= 1'b0;
		else
			o_irq <= |(irq_status & irq_mask);
	end

	// ------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------
	// ack one cycle after the request, dropped in the following cycle
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
			o_wb_ack <= 1'b0;
		else
			o_wb_ack <= bus_req & ~o_wb_ack;
	end

	// read data captured with the ack; unmapped reads give zero
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
			o_wb_dat <= '0;
		else if (bus_req && !o_wb_ack && !i_wb_we)
		begin
			o_wb_dat <= '0;
			unique case (cur_sel)
				SEL_STATUS:   o_wb_dat[7:0] <= status_word;
				SEL_UPPER:    o_wb_dat[DW-1:0] <= upper_threshold;
				SEL_LOWER:    o_wb_dat[DW-1:0] <= lower_threshold;
				SEL_DEBOUNCE: o_wb_dat[DBCNT_W-1:0] <= outside_debounce_count;
				SEL_CONFIG:   o_wb_dat[7:0] <= cfg;
				SEL_IRQ_STAT: o_wb_dat[IW-1:0] <= irq_status;
				SEL_IRQ_MASK: o_wb_dat[IW-1:0] <= irq_mask;
				SEL_NONE:     o_wb_dat <= '0;
			endcase
		end
	end

	// writes take effect at the acknowledging edge, per byte lane
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			upper_threshold        <= outside_detect_pkg::UPPER_RESET;
			lower_threshold        <= outside_detect_pkg::LOWER_RESET;
			outside_debounce_count <= outside_detect_pkg::DBCNT_RESET[DBCNT_W-1:0];
			cfg                    <= outside_detect_pkg::CONFIG_RESET;
			irq_mask               <= '0;
		end
		else if (wr_commit)
		begin
			unique case (cur_sel)
				SEL_UPPER:
				begin
					if (i_wb_sel[0])
						upper_threshold[7:0] <= i_wb_dat[7:0];
					if (i_wb_sel[1])
						upper_threshold[DW-1:8] <= i_wb_dat[DW-1:8];
				end
				SEL_LOWER:
				begin
					if (i_wb_sel[0])
						lower_threshold[7:0] <= i_wb_dat[7:0];
					if (i_wb_sel[1])
						lower_threshold[DW-1:8] <= i_wb_dat[DW-1:8];
				end
				SEL_DEBOUNCE:
				begin
					if (i_wb_sel[0])
						outside_debounce_count <= i_wb_dat[DBCNT_W-1:0];
				end
				SEL_CONFIG:
				begin
					if (i_wb_sel[0])
						cfg <= i_wb_dat[7:0];
				end
				SEL_IRQ_MASK:
				begin
					if (i_wb_sel[0])
						irq_mask <= i_wb_dat[IW-1:0];
				end
				SEL_STATUS, SEL_IRQ_STAT, SEL_NONE:
				begin
				end
			endcase
		end
	end

endmodule // outside_threshold_event_detect

// File: src/outside_detect_pkg.sv
/*
 * shared constants and carriers of the outside-of-thresholds event detector:
 * register offsets, field positions, reset values and the sample carrier.
 * assumes a 32-bit classic wishbone bus with byte addresses.
 */
package outside_detect_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int DATA_W   = 12;
	localparam int AXES     = 3;
	localparam int WB_AW    = 8;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [WB_AW-1:0] OFS_STATUS   = 8'h00;
	localparam logic [WB_AW-1:0] OFS_UPPER    = 8'h04;
	localparam logic [WB_AW-1:0] OFS_LOWER    = 8'h08;
	localparam logic [WB_AW-1:0] OFS_DEBOUNCE = 8'h0C;
	localparam logic [WB_AW-1:0] OFS_CONFIG   = 8'h10;
	localparam logic [WB_AW-1:0] OFS_IRQ_STAT = 8'h14;
	localparam logic [WB_AW-1:0] OFS_IRQ_MASK = 8'h18;

	// ------------------------------------------------------------
	// status register fields
	// ------------------------------------------------------------
	localparam int ST_ACTIVE_BIT = 7;
	localparam int ST_X_FLAG_BIT = 5;
	localparam int ST_AXIS_STEP  = 2;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// ------------------------------------------------------------
	// interrupt status fields
	// ------------------------------------------------------------
	localparam int IRQ_RISE_BIT = 0;
	localparam int IRQ_FALL_BIT = 1;
	localparam int IRQ_W        = 2;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] UPPER_RESET = 12'h000;
	localparam logic [DATA_W-1:0] LOWER_RESET = 12'h000;
	localparam logic [7:0]        DBCNT_RESET = 8'h00;

	// configuration register, bit 7 downward
	typedef struct packed {
		logic route_pin_two;
		logic route_pin_one;
		logic wake_on_outside_event;
		logic relative_mode;
		logic outside_event_latch_enable;
		logic x_outside_enable;
		logic y_outside_enable;
		logic z_outside_enable;
	} cfg_s;

	localparam cfg_s CONFIG_RESET = 8'h00;

	// one output-data-rate sample triplet
	typedef struct packed {
		logic signed [DATA_W-1:0] x;
		logic signed [DATA_W-1:0] y;
		logic signed [DATA_W-1:0] z;
	} axis_sample_s;

endpackage

// File: testbench/outside_detect_asserts.sv
/*
 * port checker of the outside event detector: bus handshake, pin routing,
 * wake restart, event flag timing and interrupt output timing.
 * assumes one clock i_clk_sys and active-low asynchronous reset i_rstn.
 */
`timescale 1ns/1ns

module outside_detect_asserts (
	input  wire logic i_clk_sys,
	input  wire logic i_rstn,
	input  wire logic i_wb_cyc,
	input  wire logic i_wb_stb,
	input  wire logic i_odr_tick,
	input  wire logic o_wb_ack,
	input  wire logic o_wake_timer_restart,
	input  wire logic o_sleep_blocked,
	input  wire logic o_interrupt_pin_one,
	input  wire logic o_interrupt_pin_two,
	input  wire logic o_irq
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);

	// --------------------
	// bus handshake steps
	// --------------------
	sequence s_req;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	sequence s_ack;
		o_wb_ack ##1 !o_wb_ack;
	endsequence

	a_bus_answer: assert property (s_req |=> s_ack)
		else $error("ack not one pulse after request");
	a_ack_needs_req: assert property (o_wb_ack |-> $past(i_wb_stb))
		else $error("ack without request");

	// --------------------
	// event flag consumers
	// --------------------
	a_pin_one_flag: assert property (o_interrupt_pin_one |-> o_sleep_blocked)
		else $error("pin one high without event");
	a_pin_two_flag: assert property (o_interrupt_pin_two |-> o_sleep_blocked)
		else $error("pin two high without event");
	a_restart_cause: assert property (o_wake_timer_restart |->
		$past(i_odr_tick) && o_sleep_blocked)
		else $error("restart without tick and event");
	a_rise_on_tick: assert property ($rose(o_sleep_blocked) |->
		$past(i_odr_tick, 2))
		else $error("event rose without a tick");
	a_fall_cause: assert property ($fell(o_sleep_blocked) |->
		$past(i_odr_tick, 2) || $past(o_wb_ack, 2))
		else $error("event fell without tick or read");

	// --------------------
	// interrupt output
	// --------------------
	a_irq_rise: assert property ($rose(o_irq) |-> $past(o_wb_ack, 2) ||
		($past(o_sleep_blocked) != $past(o_sleep_blocked, 2)))
		else $error("irq rose without event edge");
	a_irq_fall: assert property ($fell(o_irq) |-> $past(o_wb_ack, 2))
		else $error("irq fell without bus access");
endmodule // outside_detect_asserts

bind outside_threshold_event_detect outside_detect_asserts u_chk (
	.i_clk_sys(i_clk_sys),
	.i_rstn(i_rstn),
	.i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb),
	.i_odr_tick(i_odr_tick),
	.o_wb_ack(o_wb_ack),
	.o_wake_timer_restart(o_wake_timer_restart),
	.o_sleep_blocked(o_sleep_blocked),
	.o_interrupt_pin_one(o_interrupt_pin_one),
	.o_interrupt_pin_two(o_interrupt_pin_two),
	.o_irq(o_irq)
);

// File: testbench/outside_threshold_event_detect_test.sv
/*
 * self-checking bench of the outside event detector: registers, flags,
 * debounce, relative mode, latching, pin routing and interrupts.
 * assumes the design package and the bound port checker.
 */
`timescale 1ns/1ns

module outside_threshold_event_detect_test;
	// --------------------
	// signals
	// --------------------
	localparam logic [7:0] A_ST = outside_detect_pkg::OFS_STATUS;
	localparam logic [7:0] A_UP = outside_detect_pkg::OFS_UPPER;
	localparam logic [7:0] A_LO = outside_detect_pkg::OFS_LOWER;
	localparam logic [7:0] A_DB = outside_detect_pkg::OFS_DEBOUNCE;
	localparam logic [7:0] A_CF = outside_detect_pkg::OFS_CONFIG;
	localparam logic [7:0] A_IS = outside_detect_pkg::OFS_IRQ_STAT;
	localparam logic [7:0] A_IM = outside_detect_pkg::OFS_IRQ_MASK;
	localparam int U = 100;
	localparam int L = -100;
	logic        clk;
	logic        rstn;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [31:0] dat;
	logic [31:0] rdat;
	logic        ack;
	logic        odr;
	logic [35:0] smp;
	logic        rstrt;
	logic        slp;
	logic        pin1;
	logic        pin2;
	logic        irq;
	logic [31:0] seed;
	logic [63:0] q[$];
	logic [63:0] e;
	int          tbl[6] = '{100, -100, 99, -99, 101, -101};
	int          err_total;
	int          checks;
	int          ncyc;
	int          nrst;

	outside_threshold_event_detect #(.DBCNT_W(8)) dut (
		.i_clk_sys(clk), .i_rstn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(dat),
		.o_wb_dat(rdat), .o_wb_ack(ack), .i_odr_tick(odr), .i_sample(smp),
		.o_wake_timer_restart(rstrt), .o_sleep_blocked(slp),
		.o_interrupt_pin_one(pin1), .o_interrupt_pin_two(pin2), .o_irq(irq)
	);

	// --------------------
	// helpers
	// --------------------
	function logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	// boundary values favoured over plain random ones
	function int pick();
		seed = xs(seed);
		if (seed[2:0] < 3'h6)
			return tbl[seed[2:0]];
		return int'($signed(seed[14:3]));
	endfunction

	// flag and polarity of one axis
	function logic [1:0] ax(input int v);
		return {v >= U || v <= L, v >= U};
	endfunction

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do
			@(posedge clk);
		while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
		q.push_back({m, x});
		wb(1'b0, a, 32'h0);
	endtask

	// one sample period, random data outside the tick
	task tk(input int x, input int y, input int z);
		@(posedge clk);
		odr <= 1'b1;
		smp <= {x[11:0], y[11:0], z[11:0]};
		@(posedge clk);
		odr <= 1'b0;
		seed = xs(seed);
		smp <= {seed, seed[3:0]};
	endtask

	task chk(input string nm, input logic x, input logic s);
		checks++;
		if (s !== x)
		begin
			err_total++;
			$display("BAD %s exp %b seen %b", nm, x, s);
		end
	endtask

	task done(input string nm);
		$display("test %s done", nm);
	endtask

	task close_out();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// --------------------
	// processes
	// --------------------
	// clock of 10 ns
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// compare read data against the oldest note
	always @(posedge clk)
		if (ack === 1'b1 && !we)
		begin
			e = q.pop_front();
			checks++;
			if (((rdat ^ e[31:0]) & e[63:32]) !== 32'h0)
			begin
				err_total++;
				$display("BAD rd_data exp %h seen %h", e[31:0], rdat);
			end
		end

	// count wake restarts and cut a hang short
	always @(posedge clk)
	begin
		ncyc++;
		if (rstrt === 1'b1)
			nrst++;
		if (ncyc == 20000)
		begin
			err_total++;
			close_out();
		end
	end

	// main sequence
	initial
	begin
		int x;
		int y;
		int z;
		int n0;
		logic [1:0] a;
		logic [1:0] b;
		logic [1:0] c;
		logic [7:0] ev;
		logic [7:0] mv;
		rstn = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		dat = 32'h0;
		odr = 1'b0;
		smp = 36'h0;
		seed = 32'hC658;
		err_total = 0;
		checks = 0;
		ncyc = 0;
		nrst = 0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		// reset values, read-only and unmapped places
		wr(A_ST, 32'hFF);
		rd(A_ST, 32'h0, 32'hFF);
		rd(A_CF, 32'h0, 32'hFF);
		rd(8'h40, 32'h0, 32'hFFFFFFFF);
		done("reset");
		wr(A_UP, 32'h064);
		wr(A_LO, 32'hF9C);
		wr(A_CF, 32'h67);
		// x on the upper threshold twice, so the wake timer restarts
		n0 = nrst;
		tk(U, 0, 0);
		tk(U, 0, 0);
		repeat (3) @(posedge clk);
		chk("restart", 1'b1, nrst == n0 + 1);
		rd(A_ST, 32'hB0, 32'hFF);
		chk("sleep", 1'b1, slp);
		chk("pin_one", 1'b1, pin1);
		chk("pin_two", 1'b0, pin2);
		chk("irq", 1'b0, irq);
		tk(0, 0, 0);
		rd(A_ST, 32'h0, 32'hAA);
		chk("sleep", 1'b0, slp);
		done("axis");
		// random samples, each followed by a quiet period
		repeat (12)
		begin
			x = pick();
			y = pick();
			z = pick();
			a = ax(x);
			b = ax(y);
			c = ax(z);
			ev = {a[1] | b[1] | c[1], 1'b0, a, b, c};
			mv = {3'h7, a[1], 1'b1, b[1], 1'b1, c[1]};
			tk(x, y, z);
			rd(A_ST, {24'h0, ev}, {24'h0, mv});
			tk(0, 0, 0);
		end
		done("random");
		// debounce of three periods, broken once
		wr(A_DB, 32'h3);
		tk(U, 0, 0);
		tk(U, 0, 0);
		rd(A_ST, 32'h0, 32'h80);
		tk(0, 0, 0);
		tk(U, 0, 0);
		tk(U, 0, 0);
		rd(A_ST, 32'h0, 32'h80);
		tk(U, 0, 0);
		rd(A_ST, 32'h80, 32'h80);
		tk(0, 0, 0);
		wr(A_DB, 32'h0);
		done("debounce");
		// no axis enabled
		wr(A_CF, 32'h60);
		tk(U, U, U);
		tk(L, L, L);
		rd(A_ST, 32'h0, 32'h80);
		chk("sleep", 1'b0, slp);
		done("enables");
		// relative mode on x
		wr(A_CF, 32'h74);
		tk(500, 0, 0);
		tk(550, 0, 0);
		rd(A_ST, 32'h0, 32'hA0);
		tk(650, 0, 0);
		rd(A_ST, 32'hB0, 32'hB0);
		tk(650, 0, 0);
		tk(550, 0, 0);
		rd(A_ST, 32'hA0, 32'hB0);
		tk(550, 0, 0);
		done("relative");
		// latched event on pin two, rise interrupt unmasked
		wr(A_CF, 32'hAC);
		rd(A_IS, 32'h3, 32'h3);
		wr(A_IM, 32'h1);
		tk(L, 0, 0);
		tk(0, 0, 0);
		@(posedge clk);
		chk("pin_two", 1'b1, pin2);
		chk("pin_one", 1'b0, pin1);
		chk("irq", 1'b1, irq);
		rd(A_ST, 32'hA0, 32'hB0);
		rd(A_ST, 32'h0, 32'hA0);
		rd(A_IS, 32'h3, 32'h3);
		repeat (2) @(posedge clk);
		chk("irq", 1'b0, irq);
		done("latch");
		close_out();
	end
endmodule // outside_threshold_event_detect_test
